// *** logic/reloadable_modulo_counter.sv ***
// What this block does
// - each enabled cycle without a reload, the stored step is added to the count.
// - count reaching or passing the modulo bound wraps by subtracting the bound.
// - a negative step taking count below zero wraps back into zero..bound-1.
// - the count is always shown on one output with no valid flag.
// - count, bound and step live in registers set from parameters on reset.
// - the reset setup is one vector: count, then bound, then step.
// - while reload is high, value, step and bound inputs are captured.
// - the output shows the loaded value from the clock edge that takes the reload, not while reload is high.
// - after reload drops, counting resumes from the freshly loaded values.
// - value and count are unsigned; the step may be signed.
// - signed step support is a build-time option, it costs logic.
module reloadable_modulo_counter #(
  parameter modulo_counter_pkg::setup_t SETUP = modulo_counter_pkg::SETUP_DEFAULT,
  parameter bit SIGNED_STEP = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic count_enable_in,
  input wire logic reload_strobe_in,
  input wire modulo_counter_pkg::reload_data_t reload_data_in,
  output logic [modulo_counter_pkg::CNT_W-1:0] count_out
);

  // =====================================
  // state
  modulo_counter_pkg::counter_state_t state_reg;
  modulo_counter_pkg::counter_state_t state_next;
  logic [modulo_counter_pkg::EXT_W-1:0] sum_ext;
  logic [modulo_counter_pkg::EXT_W-1:0] mod_ext;
  logic step_neg;
  logic under_wrap;
  logic over_wrap;

  // extend to the guard width; sign-extends only when signed steps are built in
  function automatic logic [modulo_counter_pkg::EXT_W-1:0] extend(
    input logic [modulo_counter_pkg::CNT_W-1:0] v,
    input logic as_signed
  );
    logic s;
    s = as_signed & v[modulo_counter_pkg::CNT_W-1];
    extend = {{(modulo_counter_pkg::EXT_W - modulo_counter_pkg::CNT_W){s}}, v};
  endfunction : extend

  // =====================================
  // next state
  always_comb begin
    state_next = state_reg;
    step_neg = SIGNED_STEP & state_reg.step[modulo_counter_pkg::CNT_W-1];
    mod_ext = extend(state_reg.modulo, 1'b0);
    sum_ext = extend(state_reg.count, 1'b0) + extend(state_reg.step, SIGNED_STEP);
    under_wrap = sum_ext[modulo_counter_pkg::EXT_W-1];
    over_wrap = !under_wrap && (sum_ext >= mod_ext);
    if (reload_strobe_in) begin
      // reload wins over enable, no increment this cycle
      state_next.count = reload_data_in.value;
      state_next.step = reload_data_in.step;
      state_next.modulo = reload_data_in.modulo;
    end else if (count_enable_in) begin
      if (under_wrap) begin
        state_next.count = modulo_counter_pkg::CNT_W'(sum_ext + mod_ext);
      end else if (over_wrap) begin
        state_next.count = modulo_counter_pkg::CNT_W'(sum_ext - mod_ext);
      end else begin
        state_next.count = modulo_counter_pkg::CNT_W'(sum_ext);
      end
    end
  end

  // =====================================
  // registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= SETUP;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered output: a reload shows from the edge that takes it
  assign count_out = state_reg.count;

  // =====================================
  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  logic [modulo_counter_pkg::EXT_W-1:0] step_mag;
  logic legal_now;
  // a negative step is judged by its size, else its raw unsigned bits would read as a huge step
  assign step_mag = step_neg ? -extend(state_reg.step, 1'b1) : extend(state_reg.step, 1'b0);
  assign legal_now = (state_reg.modulo != {modulo_counter_pkg::CNT_W{1'b0}})
    && (state_reg.count < state_reg.modulo)
    && (step_mag <= mod_ext);

  sequence reload_taken;
    reload_strobe_in;
  endsequence

  sequence plain_step;
    !reload_strobe_in && count_enable_in && !under_wrap && !over_wrap;
  endsequence

  sequence enabled_step;
    !reload_strobe_in && count_enable_in;
  endsequence

  sequence wrap_up_step;
    !reload_strobe_in && count_enable_in && over_wrap;
  endsequence

  sequence wrap_down_step;
    !reload_strobe_in && count_enable_in && under_wrap;
  endsequence

  // =====================================
  // checks: reset and reload
  reset_setup_a: assert property (disable iff (1'b0) rst_in |=> state_reg == SETUP)
    else $error("reset did not load setup vector");

  reload_capture_a: assert property (reload_taken |=>
    state_reg.step == $past(reload_data_in.step)
    && state_reg.modulo == $past(reload_data_in.modulo))
    else $error("reload did not capture step and bound");

  reload_shows_a: assert property (reload_taken |=> count_out == $past(reload_data_in.value))
    else $error("loaded value not on count output");

  reload_priority_a: assert property (reload_taken ##0 count_enable_in |=>
    count_out == $past(reload_data_in.value))
    else $error("enable applied during reload");

  // =====================================
  // checks: counting
  step_add_a: assert property (plain_step |=>
    count_out == $past(modulo_counter_pkg::CNT_W'(sum_ext)))
    else $error("enabled count did not add step");

  idle_hold_a: assert property (!reload_strobe_in && !count_enable_in |=> $stable(state_reg))
    else $error("count moved while disabled");

  wrap_up_a: assert property (!reload_strobe_in && count_enable_in && over_wrap |=>
    count_out == $past(modulo_counter_pkg::CNT_W'(sum_ext - mod_ext)))
    else $error("overflow did not wrap by bound");

  wrap_down_a: assert property (!reload_strobe_in && count_enable_in && under_wrap |=>
    count_out < state_reg.modulo)
    else $error("underflow left count out of range");

  in_range_a: assert property (legal_now && !reload_strobe_in |=> count_out < state_reg.modulo)
    else $error("count left legal range");

  resume_count_a: assert property (reload_taken ##1 plain_step |=>
    count_out == $past(reload_data_in.value, 2) + $past(reload_data_in.step, 2))
    else $error("counting did not resume from loaded values");

  resume_over_a: assert property (reload_taken ##1 wrap_up_step |=>
    count_out == modulo_counter_pkg::CNT_W'($past(reload_data_in.value, 2)
    + $past(reload_data_in.step, 2) - $past(reload_data_in.modulo, 2)))
    else $error("wrap after reload used stale values");

  resume_under_a: assert property (reload_taken ##1 wrap_down_step |=>
    count_out == modulo_counter_pkg::CNT_W'($past(reload_data_in.value, 2)
    + $past(reload_data_in.step, 2) + $past(reload_data_in.modulo, 2)))
    else $error("underflow after reload used stale values");

  // =====================================
  // checks: held state
  bound_hold_a: assert property (!reload_strobe_in |=>
    state_reg.modulo == $past(state_reg.modulo)
    && state_reg.step == $past(state_reg.step))
    else $error("step or bound moved without reload");

  setup_order_a: assert property (disable iff (1'b0) rst_in |=>
    count_out == SETUP[$bits(SETUP)-1 -: modulo_counter_pkg::CNT_W]
    && state_reg.step == SETUP[modulo_counter_pkg::CNT_W-1:0])
    else $error("reset vector taken in wrong order");

  legal_keep_a: assert property (legal_now && !reload_strobe_in |=> legal_now)
    else $error("legal setup became illegal");

  // =====================================
  // checks: direction and wrap size
  step_sum_a: assert property (plain_step |=>
    count_out == modulo_counter_pkg::CNT_W'($past(count_out) + $past(state_reg.step)))
    else $error("enabled count is not count plus step");

  step_rises_a: assert property (plain_step ##0 !step_neg |=>
    count_out >= $past(count_out))
    else $error("positive step lowered the count");

  step_falls_a: assert property (plain_step ##0 step_neg |=>
    count_out < $past(count_out))
    else $error("negative step did not lower the count");

  wrap_up_sum_a: assert property (wrap_up_step |=>
    count_out == modulo_counter_pkg::CNT_W'($past(count_out) + $past(state_reg.step)
    - $past(state_reg.modulo)))
    else $error("overflow wrap gave wrong value");

  wrap_down_sum_a: assert property (wrap_down_step |=>
    count_out == modulo_counter_pkg::CNT_W'($past(count_out) + $past(state_reg.step)
    + $past(state_reg.modulo)))
    else $error("underflow wrap gave wrong value");

  wrap_up_drop_a: assert property (wrap_up_step ##0 legal_now |=>
    count_out <= $past(count_out))
    else $error("overflow wrap raised the count");

  wrap_down_rise_a: assert property (wrap_down_step ##0 legal_now |=>
    count_out >= $past(count_out))
    else $error("underflow wrap lowered the count");

  // =====================================
  // checks: build options
  unsigned_fold_a: assert property (enabled_step ##0 !SIGNED_STEP |=>
    count_out == modulo_counter_pkg::CNT_W'($past(count_out) + $past(state_reg.step))
    || count_out == modulo_counter_pkg::CNT_W'($past(count_out) + $past(state_reg.step)
    - $past(state_reg.modulo)))
    else $error("unsigned step wrapped downward");

endmodule : reloadable_modulo_counter

// *** logic/modulo_counter_pkg.sv ***
package modulo_counter_pkg;

  // =====================================
  // widths
  localparam int CNT_W = 16;
  // two guard bits: one for carry, one for sign of an underflow
  localparam int EXT_W = CNT_W + 2;

  // =====================================
  // reset setup defaults, order: count, modulo, step
  localparam logic [CNT_W-1:0] INIT_COUNT = 16'h0000;
  localparam logic [CNT_W-1:0] INIT_MODULO = 16'h000A;
  localparam logic [CNT_W-1:0] INIT_STEP = 16'h0001;
  localparam logic [1:0] GUARD_ZERO = 2'h0;

  // =====================================
  // carriers
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] modulo;
    logic [CNT_W-1:0] step;
  } setup_t;

  typedef struct packed {
    logic [CNT_W-1:0] value;
    logic [CNT_W-1:0] step;
    logic [CNT_W-1:0] modulo;
  } reload_data_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] modulo;
    logic [CNT_W-1:0] step;
  } counter_state_t;

  localparam setup_t SETUP_DEFAULT = '{count: INIT_COUNT, modulo: INIT_MODULO, step: INIT_STEP};

endpackage : modulo_counter_pkg

// *** dv/counter_driver.sv ***
module counter_driver (
  input wire logic sys_clk_in,
  output logic count_enable_out,
  output logic reload_strobe_out,
  output modulo_counter_pkg::reload_data_t reload_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    count_enable_out = 1'h0;
    reload_strobe_out = 1'h0;
    reload_data_out = '0;
  end
  // only setups legal for the signed build are loaded; step FFFD with bound 000A is illegal for the unsigned build
  task automatic apply(input logic en, input logic ld, input modulo_counter_pkg::reload_data_t d);
    @(negedge sys_clk_in);
    count_enable_out = en;
    reload_strobe_out = ld;
    // data is ignored off reload, so keep it moving
    reload_data_out = ld ? d : ~reload_data_out;
  endtask : apply
endmodule : counter_driver

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [modulo_counter_pkg::CNT_W-1:0] cnt_t;
  typedef struct packed {logic en; logic ld; modulo_counter_pkg::reload_data_t d; cnt_t q;} row_t;
  localparam modulo_counter_pkg::setup_t SETUP = '{count: 16'h0003, modulo: 16'h0007, step: 16'h0002};
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic en;
  logic ld;
  modulo_counter_pkg::reload_data_t d;
  cnt_t q;
  cnt_t q_u;
  int num_errors = 0;
  int tests_run = 0;
  // ===========================================
  // rows: enable, reload, load data, count after the edge
  row_t rows [12] = '{'{1'h1, 1'h0, 48'h0, 16'h0005}, '{1'h1, 1'h0, 48'h0, 16'h0000},
    '{1'h0, 1'h1, 48'h0008_0003_000A, 16'h0008}, '{1'h1, 1'h0, 48'h0, 16'h0001},
    '{1'h1, 1'h0, 48'h0, 16'h0004}, '{1'h0, 1'h1, 48'h0001_0002_000A, 16'h0001},
    '{1'h1, 1'h0, 48'h0, 16'h0003}, '{1'h1, 1'h1, 48'h0009_0001_000A, 16'h0009},
    '{1'h1, 1'h0, 48'h0, 16'h0000}, '{1'h0, 1'h1, 48'h0002_FFFD_000A, 16'h0002},
    '{1'h1, 1'h0, 48'h0, 16'h0009}, '{1'h0, 1'h0, 48'h0, 16'h0009}};
  initial begin
    forever begin
      #2 sys_clk_in = ~sys_clk_in;
    end
  end
  counter_driver counter_driver_inst (.sys_clk_in(sys_clk_in), .count_enable_out(en),
    .reload_strobe_out(ld), .reload_data_out(d));
  reloadable_modulo_counter #(.SETUP(SETUP), .SIGNED_STEP(1'h1)) reloadable_modulo_counter_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .count_enable_in(en),
    .reload_strobe_in(ld), .reload_data_in(d), .count_out(q));
  // same stimulus with the step taken as unsigned: the other build choice
  if (1'b1) begin : unsigned_build
    reloadable_modulo_counter #(.SETUP(SETUP), .SIGNED_STEP(1'h0))
      reloadable_modulo_counter_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .count_enable_in(en), .reload_strobe_in(ld), .reload_data_in(d), .count_out(q_u));
  end
  task automatic check_count(input string what, input cnt_t exp, input cnt_t seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_count
  task automatic step_row(input row_t r);
    counter_driver_inst.apply(r.en, r.ld, r.d);
    @(posedge sys_clk_in);
    #1;
    check_count("count", r.q, q);
  endtask : step_row
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // ===========================================
  // sequence
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'h0;
    check_count("reset count", SETUP.count, q);
    $display("test reset done");
    foreach (rows[i]) begin
      step_row(rows[i]);
    end
    $display("test rows done");
    // mid-run reset must also restore bound and step, not only count
    @(negedge sys_clk_in);
    rst_in = 1'h1;
    @(posedge sys_clk_in);
    #1;
    check_count("mid reset count", 16'h0003, q);
    @(negedge sys_clk_in);
    rst_in = 1'h0;
    step_row('{1'h1, 1'h0, 48'h0, 16'h0005});
    step_row('{1'h1, 1'h0, 48'h0, 16'h0000});
    $display("test mid reset done");
    // same step bits: signed build wraps down, unsigned build counts up
    step_row('{1'h0, 1'h1, 48'h0002_8003_FFF0, 16'h0002});
    check_count("unsigned load", 16'h0002, q_u);
    step_row('{1'h1, 1'h0, 48'h0, 16'h7FF5});
    check_count("unsigned step", 16'h8005, q_u);
    step_row('{1'h1, 1'h0, 48'h0, 16'hFFE8});
    check_count("unsigned wrap", 16'h0018, q_u);
    step_row('{1'h1, 1'h0, 48'h0, 16'h7FEB});
    check_count("unsigned next", 16'h801B, q_u);
    $display("test step sign done");
    final_report();
  end
endmodule : tb
